// >>> design/data_address_and_register_banks_defines.svh
// Constants for the data address generator and register banks.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DATA_ADDRESS_AND_REGISTER_BANKS_DEFINES_SVH
`define DATA_ADDRESS_AND_REGISTER_BANKS_DEFINES_SVH

// ****************************************************************
// APB register offsets
// ****************************************************************
`define BANK_CTRL_OFFSET 8'h00
`define STACK_PTR_OFFSET 8'h04
`define BANK_STATUS_OFFSET 8'h08
`define GPR_WINDOW_BASE 8'h40
`define GPR_WINDOW_LAST 8'h7c

// ****************************************************************
// Field positions of the bank control register
// ****************************************************************
`define CTRL_MBE_BIT 0
`define CTRL_RBE_BIT 1
`define CTRL_MBS_LSB 4
`define CTRL_RBS_LSB 8

// ****************************************************************
// Reset values
// ****************************************************************
`define MBE_RESET 1'b0
`define RBE_RESET 1'b0
`define MBS_RESET 4'h0
`define RBS_RESET 2'h0
`define SP_RESET 8'h00

// ****************************************************************
// Data memory map
// ****************************************************************
`define MEM_BANK_LOW 4'h0
`define MEM_BANK_HIGH 4'hf
`define FMEM_IRQ_FIRST 12'hfb0
`define FMEM_IRQ_LAST 12'hfbf
`define FMEM_PORT_FIRST 12'hff0
`define FMEM_PORT_LAST 12'hfff
`define PMEM_FIRST 12'hfc0
`define PAIR_XA 2'h0
`define PAIR_HL 2'h1

`endif

// >>> design/data_address_and_register_banks_pkg.sv
// Types shared by the address generator and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package data_address_and_register_banks_pkg;

   // Addressing form of a core request
   typedef enum logic [2:0] {
      mode_ptr4 = 3'h0,
      mode_ptr8 = 3'h1,
      mode_fmem_bit = 3'h2,
      mode_pmem_l = 3'h3,
      mode_h_mem_bit = 3'h4,
      mode_stack = 3'h5
   } addr_mode_t;

   // Operation carried with the request
   typedef enum logic [2:0] {
      op_move = 3'h0,
      op_exchange = 3'h1,
      op_compare_skip = 3'h2,
      op_carry_and_bit = 3'h3,
      op_carry_or_bit = 3'h4,
      op_carry_xor_bit = 3'h5,
      op_test_clear_skip = 3'h6,
      op_pop = 3'h7
   } op_t;

endpackage : data_address_and_register_banks_pkg

// >>> design/gpr_pair_mem.sv
// Register bank storage: sixteen 8-bit pair words, nibble writable.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/1ps
`default_nettype none

module gpr_pair_mem #(
   parameter int RD_PORTS = 3,
   parameter int WORDS = 16
) (
   input wire logic pclk, // Clock
   input wire logic [RD_PORTS*4-1:0] raddr, // Read addresses, packed per port
   output logic [RD_PORTS*8-1:0] rdata, // Registered read data
   input wire logic wr_en, // Write strobe
   input wire logic [1:0] wr_nib, // Nibble enables, bit 0 low nibble
   input wire logic [3:0] waddr, // Write address
   input wire logic [7:0] wdata // Write data
);

   logic [7:0] mem_q [WORDS];

   always_ff @(posedge pclk) begin
      if (wr_en && wr_nib[0]) begin
         mem_q[waddr][3:0] <= wdata[3:0];
      end
      if (wr_en && wr_nib[1]) begin
         mem_q[waddr][7:4] <= wdata[7:4];
      end
   end

   // Storage has no reset, like the array it models
   for (genvar p = 0; p < RD_PORTS; p++) begin : g_rd
      always_ff @(posedge pclk) begin
         rdata[p*8 +: 8] <= mem_q[raddr[p*4 +: 4]];
      end
   end

endmodule : gpr_pair_mem

`default_nettype wire

// >>> design/bit_op_unit.sv
// Boolean and test-clear work on one addressed bit of a nibble.
// Assumes its caller registers the results.
`timescale 1ns/1ps
`default_nettype none

module bit_op_unit (
   input wire data_address_and_register_banks_pkg::op_t op, // Operation
   input wire logic [3:0] nibble, // Data read from memory
   input wire logic [1:0] bit_sel, // Bit position
   input wire logic carry_in, // Carry before the operation
   output logic carry_out, // Carry after the operation
   output logic [3:0] nibble_out, // Data to write back
   output logic write_back, // Nibble must be written
   output logic skip // Next instruction is skipped
);

   wire logic bit_val = nibble[bit_sel];
   wire logic [3:0] bit_mask = 4'h1 << bit_sel;
   wire logic is_and = (op == data_address_and_register_banks_pkg::op_carry_and_bit);
   wire logic is_or = (op == data_address_and_register_banks_pkg::op_carry_or_bit);
   wire logic is_xor = (op == data_address_and_register_banks_pkg::op_carry_xor_bit);
   wire logic is_tclr = (op == data_address_and_register_banks_pkg::op_test_clear_skip);

   assign carry_out = is_and ? (carry_in & bit_val) :
                      is_or ? (carry_in | bit_val) :
                      is_xor ? (carry_in ^ bit_val) : carry_in;
   // Test and clear in one pass so nothing can slip between them
   assign nibble_out = is_tclr ? (nibble & ~bit_mask) : nibble;
   assign write_back = is_tclr & bit_val;
   assign skip = is_tclr & bit_val;

endmodule : bit_op_unit

`default_nettype wire

// >>> design/data_address_and_register_banks.sv
// Data memory address generator with the general-purpose register banks.
// Assumes an APB master, a decode stage that issues one request at a time,
// and a data memory array outside that returns nibbles on mem_rdata.
`timescale 1ns/1ps
`default_nettype none
`include "data_address_and_register_banks_defines.svh"

// How it works
// - 8-bit pointer access clears bit 0, pairs nibbles
// - 8-bit pointer bank chosen like 4-bit pointer
// - 8-bit pointer serves move, exchange, compare-skip
// - Fixed-area bit access ignores bank flags
// - Peripheral indirect bit access only FC0-FFF
// - Upper ten bits operand, low two from L
// - H gives high nibble, operand low nibble, bank on top
// - Carry AND/OR/XOR and test-clear-skip supported
// - Stack always in bank 0 at pointer
// - Stack serves interrupts, calls and push/pop
// - Four banks of eight nibbles at 00-1F
// - Active register bank is enable AND select
// - Register order A X L H E D C B
// - Bank enable saved, restored, loaded from vector
// - Pairs of active and bit-0-flipped bank
// - Pointer memory bank is enable AND select
// - Memory bank select takes only 0 or 15
module data_address_and_register_banks (
   input wire logic pclk, // Clock, 125 MHz
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic [7:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic req_valid, // Address request
   input wire data_address_and_register_banks_pkg::addr_mode_t req_mode, // Addressing form
   input wire data_address_and_register_banks_pkg::op_t req_op, // Operation
   input wire logic [11:0] req_operand, // Operand address field
   input wire logic [1:0] req_bit, // Operand bit field
   output logic [11:0] mem_addr, // Data memory address
   output logic mem_valid, // Address valid, one cycle
   output logic mem_pair, // 8-bit pair access
   output data_address_and_register_banks_pkg::op_t mem_op, // Operation passed on
   output logic [1:0] mem_bit, // Bit position for bit forms
   output logic addr_fault, // Operand out of range or op not allowed
   input wire logic mem_rdata_valid, // Bit phase nibble valid
   input wire logic [3:0] mem_rdata, // That nibble
   input wire logic carry_in, // Carry flag of the core
   output logic bit_done, // Bit result valid
   output logic carry_out, // New carry
   output logic [3:0] bit_wdata, // Nibble to write back
   output logic bit_write, // Write back needed
   output logic skip, // Skip next instruction
   input wire logic call_enter, // Subroutine call, pulse
   input wire logic call_return, // Subroutine return, pulse
   input wire logic irq_enter, // Interrupt entry, pulse
   input wire logic irq_return, // Interrupt return, pulse
   input wire logic vec_mbe, // Vector memory bank enable
   input wire logic vec_rbe, // Vector register bank enable
   input wire logic restore_mbe, // Popped memory bank enable
   input wire logic restore_rbe, // Popped register bank enable
   output logic save_mbe, // Memory bank enable to push
   output logic save_rbe, // Register bank enable to push
   input wire logic pair_rd, // Pair read request
   input wire logic pair_wr, // Pair write request
   input wire logic [1:0] pair_sel, // Pair: XA, HL, DE, BC
   input wire logic pair_primed, // Primed bank
   input wire logic [7:0] pair_wdata, // Pair write data
   output logic [7:0] pair_rdata, // Pair read data
   output logic [1:0] active_reg_bank, // Register bank in use
   output logic [3:0] active_mem_bank // Pointer memory bank in use
);

   // ****************************************************************
   // Bank flags and stack pointer
   // ****************************************************************
   logic mbe_q, mbe_d;
   logic rbe_q, rbe_d;
   logic [3:0] mbs_q, mbs_d;
   logic [1:0] rbs_q, rbs_d;
   logic [7:0] sp_q, sp_d;

   wire logic [3:0] mem_bank = mbe_q ? mbs_q : `MEM_BANK_LOW;
   wire logic [1:0] reg_bank = rbe_q ? rbs_q : 2'h0;
   wire logic [1:0] primed_bank = {reg_bank[1], ~reg_bank[0]};
   assign active_reg_bank = reg_bank;
   assign active_mem_bank = mem_bank;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   wire logic apb_acc = psel & penable;
   wire logic hit_ctrl = (paddr == `BANK_CTRL_OFFSET);
   wire logic hit_sp = (paddr == `STACK_PTR_OFFSET);
   wire logic hit_stat = (paddr == `BANK_STATUS_OFFSET);
   wire logic hit_gpr = (paddr >= `GPR_WINDOW_BASE) && (paddr <= `GPR_WINDOW_LAST)
                        && (paddr[1:0] == 2'h0);
   wire logic hit_any = hit_ctrl | hit_sp | hit_stat | hit_gpr;
   logic gpr_rd_wait_q;
   // Window reads wait one cycle for the registered memory port;
   // window writes wait while the core owns the write port
   wire logic gpr_rd_stall = hit_gpr & ~pwrite & ~gpr_rd_wait_q;
   wire logic gpr_wr_stall = hit_gpr & pwrite & pair_wr;
   assign pready = ~(gpr_rd_stall | gpr_wr_stall);
   wire logic apb_done = apb_acc & pready;
   wire logic apb_wr = apb_done & pwrite;
   assign pslverr = apb_acc & ~hit_any;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpr_rd_wait_q <= 1'b0;
      end else begin
         gpr_rd_wait_q <= apb_acc & hit_gpr & ~pwrite & ~gpr_rd_wait_q;
      end
   end

   // ****************************************************************
   // Register bank storage
   // ****************************************************************
   logic [23:0] gpr_rdata;
   wire logic [3:0] hl_index = {reg_bank, `PAIR_HL};
   wire logic [3:0] pair_index = {(pair_primed ? primed_bank : reg_bank), pair_sel};
   wire logic [3:0] apb_index = paddr[5:2];
   wire logic [11:0] gpr_raddr = {apb_index, pair_index, hl_index};
   wire logic core_wr = pair_wr;
   wire logic gpr_wr_en = core_wr | (apb_wr & hit_gpr);
   wire logic [3:0] gpr_waddr = core_wr ? pair_index : apb_index;
   wire logic [7:0] gpr_wdata = core_wr ? pair_wdata : pwdata[7:0];
   wire logic [7:0] hl_pair = gpr_rdata[7:0];

   gpr_pair_mem #(
      .RD_PORTS(3),
      .WORDS(16)
   ) u_gpr (
      .pclk(pclk),
      .raddr(gpr_raddr),
      .rdata(gpr_rdata),
      .wr_en(gpr_wr_en),
      .wr_nib(2'h3),
      .waddr(gpr_waddr),
      .wdata(gpr_wdata)
   );

   assign pair_rdata = gpr_rdata[15:8];

   // ****************************************************************
   // Flag and stack pointer updates
   // ****************************************************************
   wire logic mbs_ok = (pwdata[`CTRL_MBS_LSB +: 4] == `MEM_BANK_LOW)
                       || (pwdata[`CTRL_MBS_LSB +: 4] == `MEM_BANK_HIGH);
   wire logic ctrl_wr = apb_wr & hit_ctrl;
   wire logic sp_wr = apb_wr & hit_sp;
   wire logic stack_req = req_valid && (req_mode == data_address_and_register_banks_pkg::mode_stack);
   wire logic stack_pop = stack_req && (req_op == data_address_and_register_banks_pkg::op_pop);
   wire logic [7:0] sp_dec = sp_q - 8'h01;
   wire logic [7:0] sp_inc = sp_q + 8'h01;

   always_comb begin
      mbe_d = mbe_q;
      rbe_d = rbe_q;
      mbs_d = mbs_q;
      rbs_d = rbs_q;
      sp_d = sp_q;
      if (ctrl_wr) begin
         mbe_d = pwdata[`CTRL_MBE_BIT];
         rbe_d = pwdata[`CTRL_RBE_BIT];
         rbs_d = pwdata[`CTRL_RBS_LSB +: 2];
         if (mbs_ok) begin
            mbs_d = pwdata[`CTRL_MBS_LSB +: 4];
         end
      end
      // Hardware events win over a software write in the same cycle
      if (irq_enter) begin
         mbe_d = vec_mbe;
         rbe_d = vec_rbe;
      end else if (call_return || irq_return) begin
         mbe_d = restore_mbe;
         rbe_d = restore_rbe;
      end
      if (sp_wr) begin
         sp_d = pwdata[7:0];
      end
      if (stack_req) begin
         sp_d = stack_pop ? sp_inc : sp_dec;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mbe_q <= `MBE_RESET;
         rbe_q <= `RBE_RESET;
         mbs_q <= `MBS_RESET;
         rbs_q <= `RBS_RESET;
         sp_q <= `SP_RESET;
      end else begin
         mbe_q <= mbe_d;
         rbe_q <= rbe_d;
         mbs_q <= mbs_d;
         rbs_q <= rbs_d;
         sp_q <= sp_d;
      end
   end

   // Flags to push are captured as the call or interrupt starts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         save_mbe <= 1'b0;
         save_rbe <= 1'b0;
      end else if (call_enter || irq_enter) begin
         save_mbe <= mbe_q;
         save_rbe <= rbe_q;
      end
   end

   // ****************************************************************
   // Request stage: wait one edge for H and L to be read
   // ****************************************************************
   logic req_q;
   data_address_and_register_banks_pkg::addr_mode_t mode_q;
   data_address_and_register_banks_pkg::op_t op_q;
   logic [11:0] operand_q;
   logic [1:0] bit_q;
   logic [7:0] stack_off_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= 1'b0;
         mode_q <= data_address_and_register_banks_pkg::mode_ptr4;
         op_q <= data_address_and_register_banks_pkg::op_move;
         operand_q <= 12'h000;
         bit_q <= 2'h0;
         stack_off_q <= 8'h00;
      end else begin
         req_q <= req_valid;
         if (req_valid) begin
            mode_q <= req_mode;
            op_q <= req_op;
            operand_q <= req_operand;
            bit_q <= req_bit;
            stack_off_q <= stack_pop ? sp_q : sp_dec;
         end
      end
   end

   // ****************************************************************
   // Address formation
   // ****************************************************************
   wire logic [3:0] reg_h = hl_pair[7:4];
   wire logic [3:0] reg_l = hl_pair[3:0];
   wire logic in_irq_area = (operand_q >= `FMEM_IRQ_FIRST) && (operand_q <= `FMEM_IRQ_LAST);
   wire logic in_port_area = (operand_q >= `FMEM_PORT_FIRST) && (operand_q <= `FMEM_PORT_LAST);
   wire logic in_pmem_area = (operand_q >= `PMEM_FIRST);
   wire logic ptr8_op_ok = (op_q == data_address_and_register_banks_pkg::op_move)
                           || (op_q == data_address_and_register_banks_pkg::op_exchange)
                           || (op_q == data_address_and_register_banks_pkg::op_compare_skip);
   logic [11:0] addr_d;
   logic pair_d;
   logic [1:0] bit_d;
   logic fault_d;

   always_comb begin
      addr_d = {mem_bank, hl_pair};
      pair_d = 1'b0;
      bit_d = bit_q;
      fault_d = 1'b0;
      case (mode_q)
         data_address_and_register_banks_pkg::mode_ptr4: begin
            addr_d = {mem_bank, reg_h, reg_l};
         end
         data_address_and_register_banks_pkg::mode_ptr8: begin
            addr_d = {mem_bank, reg_h, reg_l[3:1], 1'b0};
            pair_d = 1'b1;
            fault_d = ~ptr8_op_ok;
         end
         data_address_and_register_banks_pkg::mode_fmem_bit: begin
            addr_d = operand_q;
            fault_d = ~(in_irq_area | in_port_area);
         end
         data_address_and_register_banks_pkg::mode_pmem_l: begin
            addr_d = {operand_q[11:2], reg_l[1:0]};
            bit_d = reg_l[1:0];
            fault_d = ~in_pmem_area;
         end
         data_address_and_register_banks_pkg::mode_h_mem_bit: begin
            addr_d = {mem_bank, reg_h, operand_q[3:0]};
         end
         data_address_and_register_banks_pkg::mode_stack: begin
            addr_d = {`MEM_BANK_LOW, stack_off_q};
         end
         default: begin
            fault_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_addr <= 12'h000;
         mem_valid <= 1'b0;
         mem_pair <= 1'b0;
         mem_op <= data_address_and_register_banks_pkg::op_move;
         mem_bit <= 2'h0;
         addr_fault <= 1'b0;
      end else begin
         mem_valid <= req_q;
         if (req_q) begin
            mem_addr <= addr_d;
            mem_pair <= pair_d;
            mem_op <= op_q;
            mem_bit <= bit_d;
            addr_fault <= fault_d;
         end
      end
   end

   // ****************************************************************
   // Bit operation on the returned nibble
   // ****************************************************************
   logic bu_carry;
   logic [3:0] bu_nibble;
   logic bu_write;
   logic bu_skip;

   bit_op_unit u_bit (
      .op(mem_op),
      .nibble(mem_rdata),
      .bit_sel(mem_bit),
      .carry_in(carry_in),
      .carry_out(bu_carry),
      .nibble_out(bu_nibble),
      .write_back(bu_write),
      .skip(bu_skip)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_done <= 1'b0;
         carry_out <= 1'b0;
         bit_wdata <= 4'h0;
         bit_write <= 1'b0;
         skip <= 1'b0;
      end else begin
         bit_done <= mem_rdata_valid;
         bit_write <= mem_rdata_valid & bu_write & ~addr_fault;
         skip <= mem_rdata_valid & bu_skip & ~addr_fault;
         if (mem_rdata_valid) begin
            carry_out <= bu_carry;
            bit_wdata <= bu_nibble;
         end
      end
   end

   // ****************************************************************
   // APB read data
   // ****************************************************************
   wire logic [31:0] ctrl_word = {22'h0, rbs_q, mbs_q, 2'h0, rbe_q, mbe_q};
   wire logic [31:0] stat_word = {10'h0, mem_addr, 2'h0, active_mem_bank, 2'h0, active_reg_bank};
   wire logic [31:0] gpr_word = {24'h0, gpr_rdata[23:16]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= hit_ctrl ? ctrl_word :
                   hit_sp ? {24'h0, sp_q} :
                   hit_stat ? stat_word : 32'h0000_0000;
      end else if (apb_acc && hit_gpr && !pwrite && !gpr_rd_wait_q) begin
         prdata <= gpr_word;
      end
   end

endmodule : data_address_and_register_banks

`default_nettype wire

// >>> verif/data_address_and_register_banks_chk.sv
// Port-level checker for the data address generator.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module data_address_and_register_banks_chk (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic req_valid, // Request
   input wire logic [2:0] req_mode, // Form
   input wire logic [11:0] req_operand, // Operand
   input wire logic [11:0] mem_addr, // Address
   input wire logic mem_valid, // Valid
   input wire logic mem_pair, // Pair
   input wire logic [2:0] mem_op, // Op
   input wire logic [1:0] mem_bit, // Bit
   input wire logic addr_fault, // Fault
   input wire logic mem_rdata_valid, // Nibble back
   input wire logic [3:0] mem_rdata, // Nibble
   input wire logic bit_done, // Done
   input wire logic [3:0] bit_wdata, // Write data
   input wire logic bit_write, // Write
   input wire logic skip, // Skip
   input wire logic [3:0] active_mem_bank // Bank
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_LAT: assert property (req_valid |-> ##2 mem_valid)
      else $error("address late");
   AST_CAUSE: assert property (mem_valid |-> $past(req_valid, 2))
      else $error("address without request");
   AST_MBS: assert property (active_mem_bank == 4'h0 || active_mem_bank == 4'hf)
      else $error("bad memory bank");
   AST_PTR8: assert property (mem_valid && $past(req_mode, 2) == 3'h1 |-> mem_pair
      && !mem_addr[0] && mem_addr[11:8] == $past(active_mem_bank))
      else $error("pair address wrong");
   AST_STACK: assert property (mem_valid && $past(req_mode, 2) == 3'h5 |-> !mem_addr[11:8])
      else $error("stack outside bank 0");
   AST_FMEM: assert property (mem_valid && $past(req_mode, 2) == 3'h2 && !addr_fault
      |-> mem_addr == $past(req_operand, 2))
      else $error("fixed bit address wrong");
   AST_PMEM: assert property (mem_valid && $past(req_mode, 2) == 3'h3 && !addr_fault
      |-> mem_addr[11:2] == $past(req_operand[11:2], 2) && mem_bit == mem_addr[1:0])
      else $error("indirect bit address wrong");
   AST_HNIB: assert property (mem_valid && $past(req_mode, 2) == 3'h4 |->
      {mem_addr[11:8], mem_addr[3:0]} == {$past(active_mem_bank), $past(req_operand[3:0], 2)})
      else $error("high nibble address wrong");
   AST_BITLAT: assert property (mem_rdata_valid |=> bit_done)
      else $error("bit result late");
   AST_TCLR: assert property (bit_done && $past(mem_op) == 3'h6 && !$past(addr_fault) |->
      skip == $past(mem_rdata[mem_bit]) && bit_write == skip && !bit_wdata[$past(mem_bit)])
      else $error("test clear wrong");
   cover property (mem_valid && mem_pair);
   cover property (bit_done && skip);
   cover property (mem_valid && addr_fault);
endmodule : data_address_and_register_banks_chk

bind data_address_and_register_banks data_address_and_register_banks_chk u_chk (.*);
`default_nettype wire

// >>> verif/data_address_and_register_banks_tb_top.sv
// Self-checking bench for the data address generator and register banks.
// Assumes the checker is bound in; one clock, bench acts as APB master.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, s) begin comparisons++; if ((s) !== (x)) begin mismatches++; $display("MISMATCH %s exp %0h got %0h", n, x, s); end end

module data_address_and_register_banks_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, mem_valid, mem_pair;
   logic addr_fault, mem_rdata_valid, carry_in, bit_done, carry_out, bit_write, skip, e;
   logic call_enter, call_return, irq_enter, irq_return, vec_mbe, vec_rbe, restore_mbe;
   logic restore_rbe, save_mbe, save_rbe, pair_rd, pair_wr, pair_primed;
   logic [7:0] paddr, pair_wdata, pair_rdata, sp;
   logic [31:0] pwdata, prdata, rs, r;
   logic [11:0] req_operand, mem_addr;
   logic [1:0] req_bit, mem_bit, pair_sel, active_reg_bank, rb;
   logic [3:0] mem_rdata, bit_wdata, active_mem_bank, mb;
   logic [7:0] g [16];
   data_address_and_register_banks_pkg::addr_mode_t req_mode;
   data_address_and_register_banks_pkg::op_t req_op, mem_op;
   int mismatches, comparisons;

   data_address_and_register_banks u_dut (.*);

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   function automatic logic [31:0] rnd();
      rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
      return rs;
   endfunction : rnd

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude

   // ************************************************************
   // APB master: pready and data are taken at the edge
   // ************************************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      {r, e} = {prdata, pslverr};
      {psel, penable} <= 2'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         conclude();
      end
   endtask : apb

   task automatic core_op();
      logic [2:0] m, o;
      logic [11:0] opd, ea;
      logic [7:0] hl;
      logic [1:0] eb;
      logic f, bv;
      r = rnd();
      m = 3'(r[2:0] % 3'd6);
      o = r[5:3];
      opd = r[19:8];
      // Random operands mostly miss the bit areas, so aim half of them in
      if (r[25]) opd[11:4] = r[26] ? 8'hff : 8'hfb;
      hl = g[{rb, 2'h1}];
      eb = (m == 3'h3) ? hl[1:0] : r[7:6];
      bv = r[20 + eb];
      f = (m == 3'h2 && opd[11:4] != 8'hff && opd[11:4] != 8'hfb) ||
         (m == 3'h3 && opd < 12'hfc0) || (m == 3'h1 && o > 3'h2);
      case (m)
         3'h0: ea = {mb, hl};
         3'h1: ea = {mb, hl[7:1], 1'b0};
         3'h2: ea = opd;
         3'h3: ea = {opd[11:2], hl[1:0]};
         3'h4: ea = {mb, hl[7:4], opd[3:0]};
         default: ea = {4'h0, (o == 3'h7) ? sp : sp - 8'h1};
      endcase
      if (m == 3'h5) sp = (o == 3'h7) ? sp + 8'h1 : sp - 8'h1;
      @(posedge pclk);
      req_mode <= data_address_and_register_banks_pkg::addr_mode_t'(m);
      req_op <= data_address_and_register_banks_pkg::op_t'(o);
      {req_valid, req_operand, req_bit} <= {1'b1, opd, r[7:6]};
      @(posedge pclk);
      req_valid <= 1'b0;
      @(posedge pclk);
      #1;
      `CHK("fault", f, addr_fault)
      if (!f) `CHK("addr", ea, mem_addr)
      if (m > 3'h1 && m < 3'h5 && o > 3'h2 && o < 3'h7) begin
         `CHK("bit", eb, mem_bit)
         @(posedge pclk);
         {mem_rdata_valid, mem_rdata, carry_in} <= {1'b1, r[23:20], r[24]};
         @(posedge pclk);
         mem_rdata_valid <= 1'b0;
         #1;
         if (o == 3'h6) `CHK("skip", !f && bv, skip)
         else `CHK("carry", o == 3'h3 ? r[24] & bv : o == 3'h4 ? r[24] | bv : r[24] ^ bv, carry_out)
      end
   endtask : core_op

   initial begin
      rs = 32'hbe3c;
      mismatches = 0;
      comparisons = 0;
      {presetn, psel, penable, pwrite, req_valid, mem_rdata_valid, carry_in, irq_return} = '0;
      {call_enter, call_return, irq_enter, vec_mbe, vec_rbe, restore_mbe, restore_rbe} = '0;
      {pair_rd, pair_wr, pair_primed, pair_sel, paddr, pwdata, req_operand, req_bit} = '0;
      {mem_rdata, pair_wdata} = '0;
      req_mode = req_mode.first();
      req_op = req_op.first();
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      `CHK("ctrl reset", 32'h0, r)
      apb(1'b1, 8'h00, 32'h2f3);
      apb(1'b1, 8'h00, 32'h253);
      `CHK("banks", 6'h2f, {active_reg_bank, active_mem_bank})
      apb(1'b1, 8'h20, 32'h0);
      `CHK("unmapped", 1'b1, e)
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         g[i] = r[7:0];
         apb(1'b1, 8'h40 + 8'(4 * i), {24'h0, g[i]});
      end
      apb(1'b0, 8'h64, 32'h0);
      `CHK("gpr", g[9], r[7:0])
      for (int k = 0; k < 8; k++) begin
         @(posedge pclk);
         {pair_sel, pair_primed} <= {k[1:0], k[2]};
         @(posedge pclk);
         #1;
         `CHK("pair", g[{1'b1, k[2], k[1:0]}], pair_rdata)
      end
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, 8'h00, p ? 32'h1f0 : 32'h2f3);
         apb(1'b1, 8'h04, 32'h80);
         {sp, mb, rb} = p ? 14'h2000 : 14'h203e;
         r = rnd();
         g[{rb, 2'h1}] = r[7:0];
         @(posedge pclk);
         {pair_wr, pair_sel, pair_primed, pair_wdata} <= {1'b1, 2'h1, 1'b0, r[7:0]};
         @(posedge pclk);
         pair_wr <= 1'b0;
         for (int n = 0; n < 40; n++) core_op();
      end
      @(posedge pclk);
      {irq_enter, vec_mbe, vec_rbe} <= 3'h7;
      @(posedge pclk);
      {irq_enter, call_enter} <= 2'h1;
      #1;
      `CHK("irq banks", 6'h1f, {active_reg_bank, active_mem_bank})
      @(posedge pclk);
      {call_enter, call_return} <= 2'h1;
      #1;
      `CHK("save", 2'h3, {save_mbe, save_rbe})
      @(posedge pclk);
      call_return <= 1'b0;
      #1;
      `CHK("restore", 6'h0, {active_reg_bank, active_mem_bank})
      conclude();
   end
endmodule : data_address_and_register_banks_tb_top
`default_nettype wire
